// ---- design/dma_pkg.sv ----
// Notes on behaviour
// - post-increment pointer step is 1 for byte, 2 for word operations
// - byte read fetches whole word, address lsb picks byte, placed low
// - two byte-wide halves share word decode, byte write strobes one half
// - word access at odd address raises address error trap
// - misaligned read completes; misaligned write suppressed; trap follows
// - byte load into working register changes only its low byte
// - sign_extend_op turns signed low byte into signed 16-bit value
// - clear_high_byte_op zeroes upper byte of working register
// - near_data_region is 0000h..1FFFh, reached by 13-bit direct field
// - outside near region only indirect; move uses 16-bit direct field
// - peripheral_control_register space is 0000h..07FFh
// - read of unused peripheral register address returns zero
// - register space decoded in 32-byte regions, implemented or not
package dma_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 16;
  localparam int          NEAR_W       = 13;
  localparam int          REGION_LSB   = 5;
  localparam int          REGION_W     = 6;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
  localparam logic [15:0] NEAR_LAST    = 16'h1FFF;
  localparam logic [15:0] PCR_LAST     = 16'h07FF;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [63:0] REGION_MAP   = 64'h0000_00C0_0000_0000;
  typedef enum logic [1:0] {DMA_MODE_INDIRECT, DMA_MODE_NEAR_DIRECT,
                            DMA_MODE_MOVE_DIRECT} dma_mode_e;
  typedef enum logic [1:0] {DMA_EXT_NONE, DMA_EXT_SIGN, DMA_EXT_ZERO} dma_ext_e;
endpackage

// ---- design/dma_lane_if.sv ----
interface dma_lane_if;
  logic [15:0] wdata;
  logic [1:0]  lane_we;
  logic [15:0] word;
  logic        is_byte;
  logic        hi_sel;
  logic [15:0] rdata;
  modport core (output wdata, output lane_we, output word, output is_byte,
                output hi_sel, input rdata);
  modport lane (input wdata, input lane_we, input word, input is_byte,
                input hi_sel, output rdata);
endinterface

// ---- design/dma_lane_sel.sv ----
module dma_lane_sel
  import dma_pkg::*;
(
  dma_lane_if.lane ln
);
  always_comb begin
    if (!ln.is_byte) begin
      ln.rdata = ln.word;
    end else if (ln.hi_sel) begin
      ln.rdata = {8'h00, ln.word[15:8]};
    end else begin
      ln.rdata = {8'h00, ln.word[7:0]};
    end
  end
endmodule

// ---- design/dma_access.sv ----
module dma_access
  import dma_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        write,
  input  wire logic        is_byte,
  input  wire dma_mode_e   mode,
  input  wire logic [15:0] direct_field,
  input  wire logic [15:0] source_pointer_register,
  input  wire logic        post_inc,
  input  wire logic        insn_done,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic [15:0] work_reg_old,
  input  wire dma_ext_e    ext_op,
  output logic [15:0]      mem_addr,
  output logic [1:0]       mem_we,
  output logic [15:0]      mem_wdata,
  output logic             mem_en,
  output logic             pcr_sel,
  output logic [15:0]      rdata,
  output logic [15:0]      work_reg_new,
  output logic [15:0]      next_pointer,
  output logic             addr_error,
  output logic             bad_mode
);
  dma_lane_if ln ();

  function automatic logic region_used(input logic [15:0] a);
    region_used = REGION_MAP[a[REGION_LSB +: REGION_W]];
  endfunction

  logic [15:0] effective_address;
  logic        misaligned;
  logic        in_pcr;
  logic        mode_ok;
  logic        err_pending;
  logic        rd_byte;
  logic        rd_hi;
  logic        rd_pcr_unused;
  logic        rd_valid;

  always_comb begin
    unique case (mode)
      DMA_MODE_NEAR_DIRECT: effective_address = {3'b000, direct_field[NEAR_W-1:0]};
      DMA_MODE_MOVE_DIRECT: effective_address = direct_field;
      default:              effective_address = source_pointer_register;
    endcase
  end
  // direct field wider than 13 bits is illegal in near direct mode
  assign mode_ok    = (mode != DMA_MODE_NEAR_DIRECT) ||
                      (direct_field <= NEAR_LAST);
  assign misaligned = !is_byte && effective_address[0];
  assign in_pcr     = effective_address <= PCR_LAST;

  assign ln.word    = mem_rdata;
  assign ln.is_byte = rd_byte;
  assign ln.hi_sel  = rd_hi;
  assign ln.wdata   = ZERO_WORD;
  assign ln.lane_we = 2'b00;
  dma_lane_sel u_lane (.ln(ln));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr     <= ZERO_WORD;
      mem_we       <= 2'b00;
      mem_wdata    <= ZERO_WORD;
      mem_en       <= 1'b0;
      pcr_sel      <= 1'b0;
      next_pointer <= ZERO_WORD;
      bad_mode     <= 1'b0;
    end else begin
      mem_en    <= req && mode_ok;
      mem_addr  <= {effective_address[15:1], 1'b0};
      pcr_sel   <= req && in_pcr;
      bad_mode  <= req && !mode_ok;
      mem_wdata <= is_byte ? {wdata[7:0], wdata[7:0]} : wdata;
      if (req && write && mode_ok && !misaligned &&
          !(in_pcr && !region_used(effective_address))) begin
        if (is_byte) begin
          mem_we <= effective_address[0] ? 2'b10 : 2'b01;
        end else begin
          mem_we <= 2'b11;
        end
      end else begin
        mem_we <= 2'b00;
      end
      if (req && post_inc && mode == DMA_MODE_INDIRECT) begin
        next_pointer <= source_pointer_register + (is_byte ? STEP_BYTE : STEP_WORD);
      end else begin
        next_pointer <= source_pointer_register;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_byte       <= 1'b0;
      rd_hi         <= 1'b0;
      rd_pcr_unused <= 1'b0;
      rd_valid      <= 1'b0;
    end else begin
      rd_valid <= req && !write && mode_ok;
      if (req && !write) begin
        rd_byte       <= is_byte;
        rd_hi         <= effective_address[0];
        rd_pcr_unused <= in_pcr && !region_used(effective_address);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata        <= ZERO_WORD;
      work_reg_new <= ZERO_WORD;
    end else begin
      if (rd_valid) begin
        rdata <= rd_pcr_unused ? ZERO_WORD : ln.rdata;
      end
      unique case (ext_op)
        DMA_EXT_SIGN: work_reg_new <= {{8{work_reg_old[7]}}, work_reg_old[7:0]};
        DMA_EXT_ZERO: work_reg_new <= {8'h00, work_reg_old[7:0]};
        default: begin
          if (rd_valid && rd_byte) begin
            work_reg_new <= {work_reg_old[15:8],
                             rd_pcr_unused ? 8'h00 : ln.rdata[7:0]};
          end else if (rd_valid) begin
            work_reg_new <= rd_pcr_unused ? ZERO_WORD : ln.rdata;
          end else begin
            work_reg_new <= work_reg_old;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_pending <= 1'b0;
      addr_error  <= 1'b0;
    end else begin
      addr_error <= 1'b0;
      if (req && misaligned) begin
        err_pending <= 1'b1;
      end
      if ((err_pending || (req && misaligned)) && insn_done) begin
        addr_error  <= 1'b1;
        err_pending <= 1'b0;
      end
    end
  end

  // checks on the registered outputs
  misaligned_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && write && misaligned |=> mem_we == 2'b00)
    else $error("misaligned write reached memory");
  byte_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && write && is_byte |=>
    (mem_we & ($past(effective_address[0]) ? 2'b01 : 2'b10)) == 2'b00)
    else $error("byte strobe on wrong lane");
  word_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && write && !is_byte && !misaligned && mode_ok && !in_pcr |=>
    mem_we == 2'b11)
    else $error("word write missing a lane");
  error_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    addr_error |=> !addr_error)
    else $error("address error longer than one cycle");
  error_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && misaligned && insn_done |=> addr_error)
    else $error("address error missing");
  error_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
    addr_error |-> $past(insn_done))
    else $error("address error before instruction end");
  read_completes_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && !write && misaligned && mode_ok |=> mem_en)
    else $error("misaligned read not completed");
  step_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && post_inc && is_byte && mode == DMA_MODE_INDIRECT |=>
    next_pointer == $past(source_pointer_register) + STEP_BYTE)
    else $error("byte step wrong");
  step_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && post_inc && !is_byte && mode == DMA_MODE_INDIRECT |=>
    next_pointer == $past(source_pointer_register) + STEP_WORD)
    else $error("word step wrong");
  byte_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid && rd_byte && !rd_pcr_unused |=>
    rdata == {8'h00, ($past(rd_hi) ? $past(mem_rdata[15:8])
                                   : $past(mem_rdata[7:0]))})
    else $error("byte read lane wrong");
  byte_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid && rd_byte && ext_op == DMA_EXT_NONE |=>
    work_reg_new[15:8] == $past(work_reg_old[15:8]))
    else $error("byte load changed high byte");
  sign_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
    ext_op == DMA_EXT_SIGN |=> work_reg_new[15:8] == {8{$past(work_reg_old[7])}})
    else $error("sign extend wrong");
  zero_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
    ext_op == DMA_EXT_ZERO |=> work_reg_new[15:8] == 8'h00)
    else $error("clear high byte wrong");
  near_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && mode == DMA_MODE_NEAR_DIRECT |=> mem_addr <= NEAR_LAST)
    else $error("near address out of region");
  near_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && mode == DMA_MODE_NEAR_DIRECT && direct_field > NEAR_LAST |=>
    bad_mode && !mem_en)
    else $error("wide near field not refused");
  pcr_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    req |=> pcr_sel == (mem_addr <= PCR_LAST))
    else $error("register space select wrong");
  region_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && write && !is_byte && !misaligned && mode_ok && in_pcr &&
    region_used(effective_address) |=> mem_we == 2'b11)
    else $error("implemented region write dropped");
  unused_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && !write && mode_ok && in_pcr && !region_used(effective_address)
    |=> ##1 rdata == ZERO_WORD)
    else $error("unused register read not zero");
  unused_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && write && !misaligned && !err_pending && in_pcr &&
    !region_used(effective_address) |=> mem_we == 2'b00 && !addr_error)
    else $error("unused register write not ignored");
endmodule

// ---- verification/dma_mem_model.sv ----
module dma_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_en,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  mem_we,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] m [16];
  logic [15:0] junk = 16'h5a5a;
  initial for (int i = 0; i < 16; i++) m[i] = 16'ha500 | 16'(i);
  always @(posedge clk) begin
    junk <= ~junk;
    if (mem_we[1]) m[mem_addr[4:1]][15:8] <= mem_wdata[15:8];
    if (mem_we[0]) m[mem_addr[4:1]][7:0] <= mem_wdata[7:0];
  end
  // idle bus toggles so stale data never passes
  assign mem_rdata = mem_en ? m[mem_addr[4:1]] : junk;
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
  import dma_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, write = 1'b0;
  logic        is_byte = 1'b0, post_inc = 1'b0;
  logic        insn_done = 1'b0, mem_en, pcr_sel, addr_error, bad_mode;
  logic [15:0] direct_field = 16'h0000, source_pointer_register = 16'h0000;
  logic [15:0] wdata = 16'h0000, work_reg_old = 16'h0000;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, rdata, work_reg_new, next_pointer;
  logic [1:0]  mem_we;
  dma_mode_e   mode = DMA_MODE_INDIRECT;
  dma_ext_e    ext_op = DMA_EXT_NONE;
  int          failures = 0, n_tests = 0;
  dma_access dut_u (.clk, .rst_n, .req, .write, .is_byte, .mode, .direct_field,
    .source_pointer_register, .post_inc, .insn_done, .wdata, .mem_rdata, .work_reg_old,
    .ext_op, .mem_addr, .mem_we, .mem_wdata, .mem_en, .pcr_sel, .rdata, .work_reg_new,
    .next_pointer, .addr_error, .bad_mode);
  dma_mem_model mem_u (.clk, .mem_en, .mem_addr, .mem_we, .mem_wdata, .mem_rdata);
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one request cycle; returns at the negedge where address, strobes and pointer show; read data shows one negedge later
  task automatic acc(input logic w, b, input dma_mode_e md, input logic [15:0] a, d);
    write = w;
    is_byte = b;
    mode = md;
    direct_field = a;
    source_pointer_register = a;
    wdata = d;
    post_inc = (md == DMA_MODE_INDIRECT);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask
  task automatic done_chk;
    insn_done = 1'b1;
    @(negedge clk);
    insn_done = 1'b0;
    chk(16'(addr_error), 16'h0001);
    @(negedge clk);
    chk(16'(addr_error), 16'h0000);
  endtask
  task automatic t_read;
    work_reg_old = 16'h3c3c;
    acc(1'b0, 1'b1, DMA_MODE_INDIRECT, 16'h0805, 16'h0000);
    chk(mem_addr, 16'h0804);
    chk(next_pointer, 16'h0806);
    acc(1'b0, 1'b0, DMA_MODE_INDIRECT, 16'h0806, 16'h0000);
    chk(rdata, 16'h00a5);
    chk(work_reg_new, 16'h3ca5);
    chk(next_pointer, 16'h0808);
    @(negedge clk);
    chk(rdata, 16'ha503);
  endtask
  task automatic t_write;
    acc(1'b1, 1'b1, DMA_MODE_INDIRECT, 16'h0809, 16'h0077);
    chk(16'(mem_we), 16'h0002);
    chk({8'h00, mem_wdata[15:8]}, 16'h0077);
    acc(1'b1, 1'b1, DMA_MODE_INDIRECT, 16'h0808, 16'h0066);
    chk(16'(mem_we), 16'h0001);
    acc(1'b0, 1'b0, DMA_MODE_INDIRECT, 16'h0808, 16'h0000);
    @(negedge clk);
    chk(rdata, 16'h7766);
  endtask
  task automatic t_misalign;
    acc(1'b1, 1'b0, DMA_MODE_INDIRECT, 16'h080b, 16'hffff);
    chk(16'(mem_we), 16'h0000);
    chk(16'(addr_error), 16'h0000);
    done_chk;
    acc(1'b0, 1'b0, DMA_MODE_INDIRECT, 16'h0809, 16'h0000);
    chk(16'(mem_en), 16'h0001);
    done_chk;
    chk(rdata, 16'h7766);
    acc(1'b0, 1'b0, DMA_MODE_INDIRECT, 16'h080a, 16'h0000);
    @(negedge clk);
    chk(rdata, 16'ha505);
  endtask
  task automatic t_pcr;
    acc(1'b0, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h07fe, 16'h0000);
    chk(16'(pcr_sel), 16'h0001);
    acc(1'b0, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h04c0, 16'h0000);
    chk(rdata, 16'h0000);
    acc(1'b1, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h0402, 16'h1234);
    chk(rdata, 16'ha500);
    chk(16'(mem_we), 16'h0000);
    insn_done = 1'b1;
    @(negedge clk);
    insn_done = 1'b0;
    chk(16'(addr_error), 16'h0000);
    acc(1'b1, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h04e4, 16'hbeef);
    chk(16'(mem_we), 16'h0003);
    acc(1'b0, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h0800, 16'h0000);
    chk(16'(pcr_sel), 16'h0000);
    chk(16'(addr_error), 16'h0000);
    acc(1'b0, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h0802, 16'h0000);
    @(negedge clk);
    chk(rdata, 16'ha501);
  endtask
  task automatic t_modes;
    acc(1'b0, 1'b0, DMA_MODE_NEAR_DIRECT, 16'h1ffe, 16'h0000);
    chk(mem_addr, 16'h1ffe);
    chk(16'(bad_mode), 16'h0000);
    acc(1'b0, 1'b0, DMA_MODE_NEAR_DIRECT, 16'h2000, 16'h0000);
    chk(16'(bad_mode), 16'h0001);
    acc(1'b0, 1'b0, DMA_MODE_MOVE_DIRECT, 16'h8000, 16'h0000);
    chk(mem_addr, 16'h8000);
    @(negedge clk);
  endtask
  // reset in mid-run drops a pending fault
  task automatic t_reset;
    acc(1'b0, 1'b0, DMA_MODE_INDIRECT, 16'h0003, 16'h0000);
    chk(next_pointer, 16'h0005);
    rst_n = 1'b0;
    @(negedge clk);
    chk(next_pointer, 16'h0000);
    rst_n = 1'b1;
    insn_done = 1'b1;
    @(negedge clk);
    insn_done = 1'b0;
    chk(16'(addr_error), 16'h0000);
  endtask
  task automatic t_ext;
    work_reg_old = 16'h1280;
    ext_op = DMA_EXT_SIGN;
    @(negedge clk);
    chk(work_reg_new, 16'hff80);
    work_reg_old = 16'hff80;
    ext_op = DMA_EXT_ZERO;
    @(negedge clk);
    chk(work_reg_new, 16'h0080);
    ext_op = DMA_EXT_NONE;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    chk(next_pointer, 16'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    t_read;
    t_write;
    t_misalign;
    t_pcr;
    t_modes;
    t_ext;
    t_reset;
    finish_test;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule
